// ==== pkg/cidc_map.vh ====
// Purpose: Register offsets, field positions and reset values for the
//          clock input divider control block.
// Assumes: 10-bit register address, 8-bit register data.
// Notes:   Definitions only.
`ifndef CIDC_MAP_VH
`define CIDC_MAP_VH

// ---------------------------------------------------------------
// Register offsets
// ---------------------------------------------------------------
`define CIDC_ADDR_W            10
`define CIDC_OFF_PRESCALE      10'h1E0
`define CIDC_OFF_INCTRL        10'h1E1
`define CIDC_OFF_SYSCTRL       10'h230
`define CIDC_OFF_UPDATE        10'h232
`define CIDC_OFF_ACTIVE_PRE    10'h240
`define CIDC_OFF_ACTIVE_IN     10'h241
`define CIDC_OFF_ACTIVE_SYS    10'h242
`define CIDC_OFF_STATUS        10'h243

// ---------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------
`define CIDC_IN_BYPASS         0
`define CIDC_IN_SEL_OSC        1
`define CIDC_IN_PD_SRC         2
`define CIDC_IN_PD_OSCIF       3
`define CIDC_IN_PD_SECTION     4
`define CIDC_SYS_SOFT_SYNC     0
`define CIDC_SYS_PD_DISTREF    1
`define CIDC_SYS_PD_SYNC       2
`define CIDC_UPD_GO            0

// ---------------------------------------------------------------
// Reset values
// ---------------------------------------------------------------
`define CIDC_RST_PRESCALE      8'h02
`define CIDC_RST_INCTRL        8'h00
`define CIDC_RST_SYSCTRL       8'h00
`define CIDC_RATIO_LAST_DIV    3'h4
`define CIDC_RATIO_BASE        3'h2

`endif

// ==== core/cidc_sync_pipe.v ====
// Purpose: Two-flop synchroniser for one level input from a pin.
// Assumes: Single clock, synchronous active-high reset.
// Notes:   First stage feeds only the second stage.
`timescale 1ns/1ps
`default_nettype none
module cidc_sync_pipe #(
  parameter RST_VAL = 1'b1
) (
  input  wire ref_clk_in,
  input  wire rst_in,
  input  wire async_in,
  output reg  sync_out
);
  reg stage1;

  always @(posedge ref_clk_in) begin
    if (rst_in) begin
      stage1   <= RST_VAL;
      sync_out <= RST_VAL;
    end else begin
      stage1   <= async_in;
      sync_out <= stage1;
    end
  end
endmodule
`default_nettype wire

// ==== core/cidc_prescaler.v ====
// Purpose: Integer divider by 2 to 6 with static hold and bypass.
// Assumes: Divided clock is a qualified enable-style output.
// Notes:   Ratio codes above the last divide hold the output.
`timescale 1ns/1ps
`default_nettype none
`include "cidc_map.vh"
module cidc_prescaler (
  input  wire       ref_clk_in,
  input  wire       rst_in,
  input  wire       src_clk_in,
  input  wire [2:0] ratio_in,
  input  wire       bypass_in,
  input  wire       hold_in,
  input  wire       restart_in,
  output reg        div_out
);
  reg  [2:0] count;
  reg        src_last;
  wire       src_rise;
  wire [2:0] div_n;
  wire [2:0] half_n;

  assign src_rise = src_clk_in & ~src_last;
  assign div_n    = ratio_in + `CIDC_RATIO_BASE;
  assign half_n   = {1'b0, div_n[2:1]};

  always @(posedge ref_clk_in) begin
    if (rst_in) begin
      count    <= 3'h0;
      src_last <= 1'b0;
      div_out  <= 1'b0;
    end else begin
      src_last <= src_clk_in;
      if (hold_in || restart_in) begin
        count   <= 3'h0;
        div_out <= 1'b0;
      end else if (bypass_in) begin
        count   <= 3'h0;
        div_out <= src_clk_in;
      end else if (ratio_in > `CIDC_RATIO_LAST_DIV) begin
        count   <= count;
        div_out <= div_out;
      end else if (src_rise) begin
        if (count >= div_n - 3'h1) begin
          count <= 3'h0;
        end else begin
          count <= count + 3'h1;
        end
        div_out <= (count + 3'h1 >= half_n) && (count != div_n - 3'h1);
      end
    end
  end
endmodule
`default_nettype wire

// ==== core/cidc_top.v ====
// Purpose: Clock input source select, prescaler, power-down and sync
//          control with buffered and active register banks.
// Assumes: Source clocks are sampled as levels on ref_clk_in.
// Notes:   Read data appear the cycle after the read strobe.
//
// Summary of operation
// - Ratio codes 0-4 divide by 2-6, reset 010; codes 5-7 hold static.
// - Input control bit 4 powers down buffer, prescaler and tree.
// - Input control bit 3 powers down the oscillator interface block.
// - Input control bit 2 powers down oscillator and external input.
// - Input control bit 1 selects oscillator when 1, external when 0.
// - Input control bit 0 bypasses the prescaler when set and the external input is selected.
// - System bit 2 powers down the sync circuitry.
// - System bit 1 powers down the distribution reference.
// - Soft sync bit high holds selected channels static.
// - Soft sync falling edge triggers a channel sync.
// - Soft sync behaves as the sync pin with inverted polarity.
// - Writing 1 to update bit 0 copies buffered into active registers.
// - Update bit clears itself after the transfer.
`timescale 1ns/1ps
`default_nettype none
`include "cidc_map.vh"
module cidc_top (
  input  wire                    ref_clk_in,
  input  wire                    rst_in,
  input  wire [`CIDC_ADDR_W-1:0] addr_in,
  input  wire [7:0]              wdata_in,
  input  wire                    wr_in,
  input  wire                    rd_in,
  output reg  [7:0]              rdata_out,
  input  wire                    ext_clk_in,
  input  wire                    osc_clk_in,
  input  wire                    sync_n_in,
  output reg                     div_clk_out,
  output reg                     pd_section_out,
  output reg                     pd_osc_if_out,
  output reg                     pd_src_out,
  output reg                     pd_sync_out,
  output reg                     pd_dist_ref_out,
  output reg                     sel_osc_out,
  output reg                     bypass_out,
  output reg                     sync_hold_out,
  output reg                     sync_pulse_out,
  output reg                     bypass_conflict_out
);

  // ---------------------------------------------------------------
  // Input synchronisers
  // ---------------------------------------------------------------
  wire ext_clk_s;
  wire osc_clk_s;
  wire sync_n_s;

  cidc_sync_pipe #(.RST_VAL(1'b0)) u_sync_ext (
    .ref_clk_in (ref_clk_in),
    .rst_in     (rst_in),
    .async_in   (ext_clk_in),
    .sync_out   (ext_clk_s)
  );

  cidc_sync_pipe #(.RST_VAL(1'b0)) u_sync_osc (
    .ref_clk_in (ref_clk_in),
    .rst_in     (rst_in),
    .async_in   (osc_clk_in),
    .sync_out   (osc_clk_s)
  );

  cidc_sync_pipe #(.RST_VAL(1'b1)) u_sync_pin (
    .ref_clk_in (ref_clk_in),
    .rst_in     (rst_in),
    .async_in   (sync_n_in),
    .sync_out   (sync_n_s)
  );

  // ---------------------------------------------------------------
  // Buffered and active register banks
  // ---------------------------------------------------------------
  reg  [7:0] buf_pre;
  reg  [7:0] buf_in;
  reg  [7:0] buf_sys;
  reg  [7:0] act_pre;
  reg  [7:0] act_in;
  reg  [7:0] act_sys;
  reg        update_go;
  wire       wr_pre;
  wire       wr_in_reg;
  wire       wr_sys;
  wire       wr_upd;

  function hit;
    input [`CIDC_ADDR_W-1:0] a;
    input [`CIDC_ADDR_W-1:0] off;
    begin
      hit = (a == off);
    end
  endfunction

  assign wr_pre    = wr_in && hit(addr_in, `CIDC_OFF_PRESCALE);
  assign wr_in_reg = wr_in && hit(addr_in, `CIDC_OFF_INCTRL);
  assign wr_sys    = wr_in && hit(addr_in, `CIDC_OFF_SYSCTRL);
  assign wr_upd    = wr_in && hit(addr_in, `CIDC_OFF_UPDATE);

  always @(posedge ref_clk_in) begin
    if (rst_in) begin
      buf_pre <= `CIDC_RST_PRESCALE;
      buf_in  <= `CIDC_RST_INCTRL;
      buf_sys <= `CIDC_RST_SYSCTRL;
    end else begin
      if (wr_pre) begin
        buf_pre <= {5'h00, wdata_in[2:0]};
      end
      if (wr_in_reg) begin
        buf_in <= {3'h0, wdata_in[4:0]};
      end
      if (wr_sys) begin
        buf_sys <= {5'h00, wdata_in[2:0]};
      end
    end
  end

  // Update pulses for one cycle then clears itself
  always @(posedge ref_clk_in) begin
    if (rst_in) begin
      update_go <= 1'b0;
    end else begin
      update_go <= wr_upd && wdata_in[`CIDC_UPD_GO];
    end
  end

  always @(posedge ref_clk_in) begin
    if (rst_in) begin
      act_pre <= `CIDC_RST_PRESCALE;
      act_in  <= `CIDC_RST_INCTRL;
      act_sys <= `CIDC_RST_SYSCTRL;
    end else if (update_go) begin
      act_pre <= buf_pre;
      act_in  <= buf_in;
      act_sys <= buf_sys;
    end
  end

  // ---------------------------------------------------------------
  // Active control decode
  // ---------------------------------------------------------------
  wire pd_section;
  wire pd_osc_if;
  wire pd_src;
  wire sel_osc;
  wire bypass;
  wire pd_sync;
  wire pd_dist_ref;
  wire soft_sync;

  assign pd_section  = act_in[`CIDC_IN_PD_SECTION];
  assign pd_osc_if   = act_in[`CIDC_IN_PD_OSCIF];
  assign pd_src      = act_in[`CIDC_IN_PD_SRC];
  assign sel_osc     = act_in[`CIDC_IN_SEL_OSC];
  assign bypass      = act_in[`CIDC_IN_BYPASS];
  assign pd_sync     = act_sys[`CIDC_SYS_PD_SYNC];
  assign pd_dist_ref = act_sys[`CIDC_SYS_PD_DISTREF];
  assign soft_sync   = act_sys[`CIDC_SYS_SOFT_SYNC];

  // ---------------------------------------------------------------
  // Source selection and prescaler
  // ---------------------------------------------------------------
  reg  src_clk;
  wire div_clk;
  wire path_dead;

  // Oscillator path also dies with its interface block
  assign path_dead = pd_section || pd_src || (sel_osc && pd_osc_if);

  always @* begin
    if (path_dead) begin
      src_clk = 1'b0;
    end else if (sel_osc) begin
      src_clk = osc_clk_s;
    end else begin
      src_clk = ext_clk_s;
    end
  end

  // ---------------------------------------------------------------
  // Sync combine
  // ---------------------------------------------------------------
  reg  hold_last;
  wire hold_now;
  wire sync_pulse;

  // Soft bit is the pin with reversed polarity
  assign hold_now   = !pd_sync && (soft_sync || !sync_n_s);
  assign sync_pulse = hold_last && !hold_now && !pd_sync;

  always @(posedge ref_clk_in) begin
    if (rst_in) begin
      hold_last <= 1'b0;
    end else begin
      hold_last <= hold_now;
    end
  end

  // Bypass ignored on the oscillator path
  cidc_prescaler u_pre (
    .ref_clk_in (ref_clk_in),
    .rst_in     (rst_in),
    .src_clk_in (src_clk),
    .ratio_in   (act_pre[2:0]),
    .bypass_in  (bypass && !sel_osc),
    .hold_in    (path_dead),
    .restart_in (sync_pulse),
    .div_out    (div_clk)
  );

  // ---------------------------------------------------------------
  // Registered outputs
  // ---------------------------------------------------------------
  always @(posedge ref_clk_in) begin
    if (rst_in) begin
      div_clk_out         <= 1'b0;
      pd_section_out      <= 1'b0;
      pd_osc_if_out       <= 1'b0;
      pd_src_out          <= 1'b0;
      pd_sync_out         <= 1'b0;
      pd_dist_ref_out     <= 1'b0;
      sel_osc_out         <= 1'b0;
      bypass_out          <= 1'b0;
      sync_hold_out       <= 1'b0;
      sync_pulse_out      <= 1'b0;
      bypass_conflict_out <= 1'b0;
    end else begin
      div_clk_out         <= div_clk;
      pd_section_out      <= pd_section;
      pd_osc_if_out       <= pd_osc_if;
      pd_src_out          <= pd_src;
      pd_sync_out         <= pd_sync;
      pd_dist_ref_out     <= pd_dist_ref;
      sel_osc_out         <= sel_osc;
      bypass_out          <= bypass && !sel_osc;
      sync_hold_out       <= hold_now;
      sync_pulse_out      <= sync_pulse;
      bypass_conflict_out <= bypass && sel_osc;
    end
  end

  // ---------------------------------------------------------------
  // Register read port
  // ---------------------------------------------------------------
  reg [7:0] next_rdata;

  always @* begin
    next_rdata = 8'h00;
    if (rd_in) begin
      case (addr_in)
        `CIDC_OFF_PRESCALE:   next_rdata = buf_pre;
        `CIDC_OFF_INCTRL:     next_rdata = buf_in;
        `CIDC_OFF_SYSCTRL:    next_rdata = buf_sys;
        `CIDC_OFF_UPDATE:     next_rdata = 8'h00;
        `CIDC_OFF_ACTIVE_PRE: next_rdata = act_pre;
        `CIDC_OFF_ACTIVE_IN:  next_rdata = act_in;
        `CIDC_OFF_ACTIVE_SYS: next_rdata = act_sys;
        `CIDC_OFF_STATUS:     next_rdata = {5'h00, sync_n_s, hold_now,
                                            div_clk};
        default:              next_rdata = 8'h00;
      endcase
    end
  end

  always @(posedge ref_clk_in) begin
    if (rst_in) begin
      rdata_out <= 8'h00;
    end else begin
      rdata_out <= next_rdata;
    end
  end
endmodule
`default_nettype wire

// ==== tb/cidc_top_monitor.sv ====
// Purpose: Port-level checks on the clock input control block.
// Assumes: One clock, synchronous active-high reset.
// Notes:   Attached by bind from the bench top file.
`timescale 1ns/1ps
`default_nettype none
`include "cidc_map.vh"
module cidc_top_monitor (
  input wire logic                    ref_clk_in,
  input wire logic                    rst_in,
  input wire logic [`CIDC_ADDR_W-1:0] addr_in,
  input wire logic [7:0]              wdata_in,
  input wire logic                    wr_in,
  input wire logic                    rd_in,
  input wire logic [7:0]              rdata_out,
  input wire logic                    ext_clk_in,
  input wire logic                    osc_clk_in,
  input wire logic                    sync_n_in,
  input wire logic                    div_clk_out,
  input wire logic                    pd_section_out,
  input wire logic                    pd_osc_if_out,
  input wire logic                    pd_src_out,
  input wire logic                    pd_sync_out,
  input wire logic                    pd_dist_ref_out,
  input wire logic                    sel_osc_out,
  input wire logic                    bypass_out,
  input wire logic                    sync_hold_out,
  input wire logic                    sync_pulse_out,
  input wire logic                    bypass_conflict_out
);
  // ---------------------------------------------------------------
  // Update history
  // ---------------------------------------------------------------
  logic [3:0] upd_hist;
  always @(posedge ref_clk_in) begin
    if (rst_in) begin
      upd_hist <= 4'h0;
    end else begin
      upd_hist <= {upd_hist[2:0],
                   wr_in & (addr_in == `CIDC_OFF_UPDATE) & wdata_in[0]};
    end
  end
  // ---------------------------------------------------------------
  // Properties
  // ---------------------------------------------------------------
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (rst_in);
  sequence s_pin_low; !sync_n_in [*3]; endsequence
  sequence s_hold_rel; $fell(sync_hold_out) && !pd_sync_out; endsequence
  sequence s_pd_long; pd_section_out [*3]; endsequence
  property p_cfg_upd;
    $changed({pd_section_out, pd_osc_if_out, pd_src_out, sel_osc_out,
      bypass_out, pd_sync_out, pd_dist_ref_out}) |-> |upd_hist[3:1];
  endproperty
  property p_upd_rd;
    rd_in && addr_in == `CIDC_OFF_UPDATE |=> rdata_out == 8'h00;
  endproperty
  property p_byp_excl; !(bypass_out && sel_osc_out); endproperty
  property p_conflict; bypass_conflict_out |-> sel_osc_out; endproperty
  property p_pd_div; s_pd_long |-> !div_clk_out; endproperty
  property p_pulse_one; sync_pulse_out |=> !sync_pulse_out; endproperty
  property p_pulse_cause;
    sync_pulse_out |-> !sync_hold_out &&
      ($past(sync_hold_out) || $past(sync_hold_out, 2));
  endproperty
  property p_rel_pulse; s_hold_rel |-> ##[0:2] sync_pulse_out; endproperty
  property p_pd_sync; pd_sync_out [*2] |-> !sync_hold_out; endproperty
  property p_hold_pin;
    s_pin_low |-> ##[0:4] (sync_hold_out || pd_sync_out);
  endproperty
  a_cfg_upd: assert property (p_cfg_upd)
    else $error("config output moved without update");
  a_upd_rd: assert property (p_upd_rd)
    else $error("update register read nonzero");
  a_byp_excl: assert property (p_byp_excl)
    else $error("bypass with oscillator selected");
  a_conflict: assert property (p_conflict)
    else $error("conflict flag without oscillator");
  a_pd_div: assert property (p_pd_div)
    else $error("divided clock active while powered down");
  a_pulse_one: assert property (p_pulse_one)
    else $error("sync pulse longer than one cycle");
  a_pulse_cause: assert property (p_pulse_cause)
    else $error("sync pulse without hold release");
  a_rel_pulse: assert property (p_rel_pulse)
    else $error("hold release gave no sync pulse");
  a_pd_sync: assert property (p_pd_sync)
    else $error("hold active with sync powered down");
  a_hold_pin: assert property (p_hold_pin)
    else $error("pin low did not hold channels");
endmodule
`default_nettype wire

// ==== tb/cidc_top_bench.sv ====
// Purpose: Directed bench for the clock input control block.
// Assumes: Source clocks made from a free counter on the bench clock.
// Notes:   Ext source period 8 cycles, oscillator 16 cycles.
`timescale 1ns/1ps
`default_nettype none
module cidc_top_bench;
  logic       ref_clk_in = 1'b0;
  logic       rst_in     = 1'b1;
  logic [9:0] addr_in    = 10'h000;
  logic [7:0] wdata_in   = 8'h00;
  logic       wr_in      = 1'b0;
  logic       rd_in      = 1'b0;
  logic       sync_n_in  = 1'b1;
  logic [3:0] cnt        = 4'h0;
  int         miscompares = 0;
  int         compares    = 0;
  wire        ext_clk_in = cnt[2];
  wire        osc_clk_in = cnt[3];
  wire [7:0]  rdata_out;
  wire        div_clk_out, pd_section_out, pd_osc_if_out, pd_src_out;
  wire        pd_sync_out, pd_dist_ref_out, sel_osc_out, bypass_out;
  wire        sync_hold_out, sync_pulse_out, bypass_conflict_out;
  wire [7:0]  in_v = {3'h0, pd_section_out, pd_osc_if_out, pd_src_out,
                      sel_osc_out, bypass_out};
  wire [7:0]  sys_v = {5'h0, pd_sync_out, pd_dist_ref_out, 1'b0};
  cidc_top cidc_top_i (.ref_clk_in(ref_clk_in), .rst_in(rst_in),
    .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
    .rdata_out(rdata_out), .ext_clk_in(ext_clk_in),
    .osc_clk_in(osc_clk_in), .sync_n_in(sync_n_in),
    .div_clk_out(div_clk_out), .pd_section_out(pd_section_out),
    .pd_osc_if_out(pd_osc_if_out), .pd_src_out(pd_src_out),
    .pd_sync_out(pd_sync_out), .pd_dist_ref_out(pd_dist_ref_out),
    .sel_osc_out(sel_osc_out), .bypass_out(bypass_out),
    .sync_hold_out(sync_hold_out), .sync_pulse_out(sync_pulse_out),
    .bypass_conflict_out(bypass_conflict_out));
  always #12.5 ref_clk_in = ~ref_clk_in;
  always @(posedge ref_clk_in) cnt <= cnt + 4'h1;
  // ---------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------
  task automatic wt(input int n);
    repeat (n) @(posedge ref_clk_in);
    #1;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    @(posedge ref_clk_in);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'b1;
    @(posedge ref_clk_in);
    wr_in <= 1'b0;
  endtask
  task automatic upd();
    wr(10'h232, 8'h01);
    wt(5);
  endtask
  task automatic rd(input logic [9:0] a, input logic [7:0] exp);
    @(posedge ref_clk_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge ref_clk_in);
    rd_in <= 1'b0;
    #1 chk(rdata_out, exp);
  endtask
  task automatic pulse(input logic [7:0] exp);
    logic [7:0] seen;
    seen = 8'h00;
    repeat (12) begin
      @(posedge ref_clk_in);
      #1;
      if (sync_pulse_out === 1'b1) seen = 8'h01;
    end
    chk(seen, exp);
  endtask
  task automatic meas(input logic [7:0] code, ctl, input int exp);
    int n;
    logic prev;
    n = 0;
    prev = 1'b1;
    wr(10'h1E0, code);
    wr(10'h1E1, ctl);
    upd();
    wt(20);
    repeat (480) begin
      @(posedge ref_clk_in);
      #1;
      if (div_clk_out === 1'b1 && prev === 1'b0) n++;
      prev = div_clk_out;
    end
    if (n >= exp - 1 && n <= exp + 1) n = exp;
    chk(n[7:0], exp[7:0]);
  endtask
  task automatic report_and_stop();
    if (miscompares == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_reset();
    rd(10'h1E0, 8'h02);
    rd(10'h1E1, 8'h00);
    rd(10'h230, 8'h00);
    rd(10'h232, 8'h00);
    rd(10'h3FF, 8'h00);
    chk(in_v | sys_v, 8'h00);
  endtask
  task automatic t_buffer();
    wr(10'h1E1, 8'h12);
    wt(8);
    chk(in_v, 8'h00);
    rd(10'h1E1, 8'h12);
    upd();
    chk(in_v, 8'h12);
    rd(10'h241, 8'h12);
  endtask
  task automatic t_bits();
    for (int b = 0; b < 5; b++) begin
      wr(10'h1E1, 8'h01 << b);
      upd();
      chk(in_v, 8'h01 << b);
    end
    wr(10'h1E1, 8'h00);
    for (int b = 1; b < 3; b++) begin
      wr(10'h230, 8'h01 << b);
      upd();
      chk(sys_v, 8'h01 << b);
    end
    wr(10'h230, 8'h00);
    wr(10'h1E1, 8'h03);
    upd();
    chk({bypass_conflict_out, sel_osc_out, bypass_out}, 8'h06);
  endtask
  task automatic t_ratio();
    for (int c = 0; c < 8; c++) meas(c, 8'h00, c < 5 ? 60 / (c + 2) : 0);
    meas(8'h00, 8'h02, 15);
    meas(8'h00, 8'h01, 60);
    meas(8'h00, 8'h10, 0);
    meas(8'h00, 8'h0A, 0);
    meas(8'h00, 8'h04, 0);
  endtask
  task automatic t_sync();
    @(posedge ref_clk_in);
    sync_n_in <= 1'b0;
    wt(8);
    chk(sync_hold_out, 8'h01);
    @(posedge ref_clk_in);
    sync_n_in <= 1'b1;
    pulse(8'h01);
    wr(10'h230, 8'h01);
    upd();
    chk(sync_hold_out, 8'h01);
    @(posedge ref_clk_in);
    sync_n_in <= 1'b0;
    wr(10'h230, 8'h00);
    upd();
    chk(sync_hold_out, 8'h01);
    @(posedge ref_clk_in);
    sync_n_in <= 1'b1;
    pulse(8'h01);
    wr(10'h230, 8'h01);
    upd();
    wr(10'h230, 8'h00);
    wr(10'h232, 8'h01);
    pulse(8'h01);
    wr(10'h230, 8'h05);
    upd();
    chk(sync_hold_out, 8'h00);
    rd(10'h242, 8'h05);
  endtask
  initial begin
    repeat (2) @(posedge ref_clk_in);
    rst_in <= 1'b0;
    wt(3);
    t_reset();
    t_buffer();
    t_bits();
    t_ratio();
    t_sync();
    report_and_stop();
  end
  initial begin
    #1000000;
    miscompares++;
    report_and_stop();
  end
endmodule
bind cidc_top cidc_top_monitor cidc_top_monitor_i (.ref_clk_in(ref_clk_in),
  .rst_in(rst_in), .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in),
  .rd_in(rd_in), .rdata_out(rdata_out), .ext_clk_in(ext_clk_in),
  .osc_clk_in(osc_clk_in), .sync_n_in(sync_n_in),
  .div_clk_out(div_clk_out), .pd_section_out(pd_section_out),
  .pd_osc_if_out(pd_osc_if_out), .pd_src_out(pd_src_out),
  .pd_sync_out(pd_sync_out), .pd_dist_ref_out(pd_dist_ref_out),
  .sel_osc_out(sel_osc_out), .bypass_out(bypass_out),
  .sync_hold_out(sync_hold_out), .sync_pulse_out(sync_pulse_out),
  .bypass_conflict_out(bypass_conflict_out));
`default_nettype wire
